//--- logic/pms_power_ctrl.sv
// Power mode sequencer and module stop registers for a microcontroller.
// Assumes the CPU core pulses sleep_req and int_accept on clk_sys, and
// that the two reset-like pins arrive asynchronously from the board.
`timescale 1ns/10ps

// What this block does
// - Stop bit at 1 halts its peripheral group; 0 lets it run.
// - High bit 7 resets to 0, read-write; software never sets it.
// - High bit 6 stops transfer controller; resets to 0.
// - High bit 5 stops free-running timer; resets to 1.
// - High bit 4 stops first 8-bit timer pair; resets to 1.
// - High bit 3 stops both pulse-width timers together; resets to 1.
// - High bits 2,1,0 stop DAC, ADC, second timer pair; reset 1.
// - Low bits 7,6,5 stop serial channels 0,1,2; reset to 1.
// - Low bits 4,3 stop two-wire channels 0,1; reset to 1.
// - Low bit 2 stops keyboard host group and its registers; resets 1.
// - Low bit 1 resets to 1, read-write, affects nothing.
// - Low bit 0 stops low-pin-count host and wake mask B; resets 1.
// - Only the sleep instruction moves from running to halted modes.
// - An accepted interrupt returns a halted mode to running.
// - Standby pin low forces hardware standby from every mode.
// - Reset pin low enters reset from any mode but hardware standby.
// - Transfer controller slow in medium, runs in sleep, obeys stop bit.
// - Transfer controller retains in low modes, reset in hardware standby.
// - Reset-halt initialises a module; retain-halt keeps registers.
// - Software standby stops CPU, oscillator; resets serial and pulse.
module pms_power_ctrl
    import pms_pkg::*;
(
    input wire logic clk_sys, // 40 MHz system clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic hw_standby_n, // Standby pin, active low, async
    input wire logic reset_n_pin, // Reset pin, active low, async
    input wire logic sleep_req, // Sleep instruction executed, pulse
    input wire logic int_accept, // Interrupt accepted, pulse
    input wire logic [3:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    output pms_mode_t mode, // Current operating mode
    output pms_group_ctl_t group_ctl, // Per-group clock enable and reset
    output pms_core_ctl_t core_ctl // CPU and oscillator control
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic hw_standby_n_meta;
    logic hw_standby_n_sync;
    logic res_meta;
    logic res_sync;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            hw_standby_n_meta <= 1'b1;
            hw_standby_n_sync <= 1'b1;
            res_meta <= 1'b1;
            res_sync <= 1'b1;
        end
        else
        begin
            hw_standby_n_meta <= hw_standby_n;
            hw_standby_n_sync <= hw_standby_n_meta;
            res_meta <= reset_n_pin;
            res_sync <= res_meta;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] module_stop_high;
    logic [7:0] module_stop_low;
    logic [2:0] sleep_cfg;
    logic in_hw_standby;
    logic in_reset;

    assign in_hw_standby = (mode == PMS_HW_STANDBY);
    assign in_reset = (mode == PMS_RESET);

    // Stop registers return to defaults in reset and hardware standby
    always_ff @(posedge clk_sys)
    begin
        if (rst || in_hw_standby || in_reset)
        begin
            module_stop_high <= PMS_STOP_HIGH_RESET;
            module_stop_low <= PMS_STOP_LOW_RESET;
        end
        else if (reg_wr && reg_addr == PMS_ADDR_STOP_HIGH)
        begin
            // bit 7 still stores a write
            module_stop_high <= reg_wdata;
        end
        else if (reg_wr && reg_addr == PMS_ADDR_STOP_LOW)
        begin
            module_stop_low <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || in_hw_standby || in_reset)
        begin
            sleep_cfg <= 3'h0;
        end
        else if (reg_wr && reg_addr == PMS_ADDR_SLEEP_CFG)
        begin
            sleep_cfg <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (!reg_rd)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_addr == PMS_ADDR_STOP_HIGH)
        begin
            reg_rdata <= module_stop_high;
        end
        else if (reg_addr == PMS_ADDR_STOP_LOW)
        begin
            reg_rdata <= module_stop_low;
        end
        else if (reg_addr == PMS_ADDR_MODE)
        begin
            reg_rdata <= {4'h0, mode};
        end
        else if (reg_addr == PMS_ADDR_SLEEP_CFG)
        begin
            reg_rdata <= {5'h00, sleep_cfg};
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------
    // Mode sequencer
    // ----------------------------------------
    pms_mode_t next_mode;
    logic running;

    assign running = (mode == PMS_HIGH_SPEED) || (mode == PMS_MEDIUM_SPEED)
        || (mode == PMS_SUBACTIVE);

    function automatic pms_mode_t halt_target(input pms_mode_t from,
        input logic [2:0] cfg);
        pms_mode_t target;
        begin
            target = PMS_SLEEP;
            if (from == PMS_SUBACTIVE)
            begin
                target = cfg[PMS_CFG_LOWSPEED] ? PMS_SUBSLEEP : PMS_WATCH;
            end
            else if (cfg[PMS_CFG_LOWSPEED])
            begin
                target = PMS_WATCH;
            end
            else if (cfg[PMS_CFG_STANDBY])
            begin
                target = PMS_SW_STANDBY;
            end
            return target;
        end
    endfunction : halt_target

    always_comb
    begin
        next_mode = mode;
        case (mode)
            PMS_RESET:
            begin
                if (res_sync)
                begin
                    next_mode = PMS_HIGH_SPEED;
                end
            end
            PMS_HIGH_SPEED, PMS_MEDIUM_SPEED:
            begin
                if (sleep_req)
                begin
                    next_mode = halt_target(mode, sleep_cfg);
                end
                else if (sleep_cfg[PMS_CFG_MEDIUM])
                begin
                    next_mode = PMS_MEDIUM_SPEED;
                end
                else
                begin
                    next_mode = PMS_HIGH_SPEED;
                end
            end
            PMS_SUBACTIVE:
            begin
                if (sleep_req)
                begin
                    next_mode = halt_target(mode, sleep_cfg);
                end
            end
            PMS_SLEEP, PMS_WATCH, PMS_SW_STANDBY:
            begin
                if (int_accept)
                begin
                    next_mode = (mode == PMS_WATCH
                        && sleep_cfg[PMS_CFG_LOWSPEED]) ? PMS_SUBACTIVE
                        : (sleep_cfg[PMS_CFG_MEDIUM] ? PMS_MEDIUM_SPEED
                        : PMS_HIGH_SPEED);
                end
            end
            PMS_SUBSLEEP:
            begin
                if (int_accept)
                begin
                    next_mode = PMS_SUBACTIVE;
                end
            end
            PMS_HW_STANDBY:
            begin
                // Leaves only through reset, as after power-up
                if (hw_standby_n_sync)
                begin
                    next_mode = PMS_RESET;
                end
            end
            default:
            begin
                next_mode = PMS_RESET;
            end
        endcase
        if (!res_sync && !in_hw_standby)
        begin
            next_mode = PMS_RESET;
        end
        if (!hw_standby_n_sync)
        begin
            next_mode = PMS_HW_STANDBY;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mode <= PMS_RESET;
        end
        else
        begin
            mode <= next_mode;
        end
    end

    // ----------------------------------------
    // Group clock enables and resets
    // ----------------------------------------
    pms_group_ctl_t next_group_ctl;
    logic periph_clk;
    logic low_mode;
    logic hw_standby_n_reset;

    always_comb
    begin
        periph_clk = (mode == PMS_HIGH_SPEED) || (mode == PMS_MEDIUM_SPEED)
            || (mode == PMS_SLEEP);
        low_mode = (mode == PMS_WATCH) || (mode == PMS_SUBACTIVE)
            || (mode == PMS_SUBSLEEP) || (mode == PMS_SW_STANDBY);
        hw_standby_n_reset = in_hw_standby || in_reset;
        next_group_ctl.clk_en = '0;
        next_group_ctl.reset = '0;
        next_group_ctl.clk_en[PMS_G_TRANSFER] = periph_clk
            && !module_stop_high[PMS_HB_TRANSFER];
        next_group_ctl.clk_en[PMS_G_FREERUN] = periph_clk
            && !module_stop_high[PMS_HB_FREERUN];
        next_group_ctl.clk_en[PMS_G_TIMER_A] = periph_clk
            && !module_stop_high[PMS_HB_TIMER_A];
        next_group_ctl.clk_en[PMS_G_PULSE] = periph_clk
            && !module_stop_high[PMS_HB_PULSE];
        next_group_ctl.clk_en[PMS_G_DAC] = periph_clk
            && !module_stop_high[PMS_HB_DAC];
        next_group_ctl.clk_en[PMS_G_ADC] = periph_clk
            && !module_stop_high[PMS_HB_ADC];
        next_group_ctl.clk_en[PMS_G_TIMER_B] = periph_clk
            && !module_stop_high[PMS_HB_TIMER_B];
        next_group_ctl.clk_en[PMS_G_SERIAL0] = periph_clk
            && !module_stop_low[PMS_LB_SERIAL0];
        next_group_ctl.clk_en[PMS_G_SERIAL1] = periph_clk
            && !module_stop_low[PMS_LB_SERIAL1];
        next_group_ctl.clk_en[PMS_G_SERIAL2] = periph_clk
            && !module_stop_low[PMS_LB_SERIAL2];
        next_group_ctl.clk_en[PMS_G_TWOWIRE0] = periph_clk
            && !module_stop_low[PMS_LB_TWOWIRE0];
        next_group_ctl.clk_en[PMS_G_TWOWIRE1] = periph_clk
            && !module_stop_low[PMS_LB_TWOWIRE1];
        next_group_ctl.clk_en[PMS_G_KEYBOARD] = periph_clk
            && !module_stop_low[PMS_LB_KEYBOARD];
        next_group_ctl.clk_en[PMS_G_LOWPIN] = periph_clk
            && !module_stop_low[PMS_LB_LOWPIN];

        next_group_ctl.reset = {PMS_NGROUP{hw_standby_n_reset}};
        next_group_ctl.reset[PMS_G_PULSE] = hw_standby_n_reset || low_mode
            || module_stop_high[PMS_HB_PULSE];
        next_group_ctl.reset[PMS_G_SERIAL0] = hw_standby_n_reset || low_mode
            || module_stop_low[PMS_LB_SERIAL0];
        next_group_ctl.reset[PMS_G_SERIAL1] = hw_standby_n_reset || low_mode
            || module_stop_low[PMS_LB_SERIAL1];
        next_group_ctl.reset[PMS_G_SERIAL2] = hw_standby_n_reset || low_mode
            || module_stop_low[PMS_LB_SERIAL2];
        next_group_ctl.reset[PMS_G_TRANSFER] = hw_standby_n_reset;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            group_ctl.clk_en <= '0;
            group_ctl.reset <= '1;
        end
        else
        begin
            group_ctl <= next_group_ctl;
        end
    end

    // ----------------------------------------
    // CPU and oscillator control
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            core_ctl <= '0;
        end
        else
        begin
            core_ctl.cpu_run <= running;
            core_ctl.cpu_slow <= (mode == PMS_MEDIUM_SPEED)
                || (mode == PMS_SUBACTIVE);
            core_ctl.main_osc_on <= periph_clk || in_reset;
            core_ctl.sub_osc_on <= !hw_standby_n_reset && (mode != PMS_SW_STANDBY);
            core_ctl.dtc_slow <= (mode == PMS_MEDIUM_SPEED);
        end
    end

endmodule : pms_power_ctrl

//--- logic/pms_pkg.sv
// Constants and types for the power mode and module stop controller.
// Assumes a single 40 MHz system clock and a synchronous active-high reset.
package pms_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0] PMS_ADDR_STOP_HIGH = 4'h0;
    localparam logic [3:0] PMS_ADDR_STOP_LOW = 4'h1;
    localparam logic [3:0] PMS_ADDR_MODE = 4'h2;
    localparam logic [3:0] PMS_ADDR_SLEEP_CFG = 4'h3;

    localparam logic [7:0] PMS_STOP_HIGH_RESET = 8'h3f;
    localparam logic [7:0] PMS_STOP_LOW_RESET = 8'hff;
    localparam logic [7:0] PMS_HIGH_WRITE_MASK = 8'h7f;

    // ----------------------------------------
    // Bit positions
    // ----------------------------------------
    localparam int PMS_HB_RESERVED = 7;
    localparam int PMS_HB_TRANSFER = 6;
    localparam int PMS_HB_FREERUN = 5;
    localparam int PMS_HB_TIMER_A = 4;
    localparam int PMS_HB_PULSE = 3;
    localparam int PMS_HB_DAC = 2;
    localparam int PMS_HB_ADC = 1;
    localparam int PMS_HB_TIMER_B = 0;
    localparam int PMS_LB_SERIAL0 = 7;
    localparam int PMS_LB_SERIAL1 = 6;
    localparam int PMS_LB_SERIAL2 = 5;
    localparam int PMS_LB_TWOWIRE0 = 4;
    localparam int PMS_LB_TWOWIRE1 = 3;
    localparam int PMS_LB_KEYBOARD = 2;
    localparam int PMS_LB_DUMMY = 1;
    localparam int PMS_LB_LOWPIN = 0;

    localparam int PMS_CFG_STANDBY = 0;
    localparam int PMS_CFG_LOWSPEED = 1;
    localparam int PMS_CFG_MEDIUM = 2;

    localparam int PMS_GROUPS = 13;

    // Group indices of the enable and reset vectors
    localparam int PMS_G_TRANSFER = 0;
    localparam int PMS_G_FREERUN = 1;
    localparam int PMS_G_TIMER_A = 2;
    localparam int PMS_G_PULSE = 3;
    localparam int PMS_G_DAC = 4;
    localparam int PMS_G_ADC = 5;
    localparam int PMS_G_TIMER_B = 6;
    localparam int PMS_G_SERIAL0 = 7;
    localparam int PMS_G_SERIAL1 = 8;
    localparam int PMS_G_SERIAL2 = 9;
    localparam int PMS_G_TWOWIRE0 = 10;
    localparam int PMS_G_TWOWIRE1 = 11;
    localparam int PMS_G_KEYBOARD = 12;
    localparam int PMS_G_LOWPIN = 13;
    localparam int PMS_NGROUP = 14;

    // ----------------------------------------
    // Operating modes
    // ----------------------------------------
    typedef enum logic [3:0] {
        PMS_RESET,
        PMS_HIGH_SPEED,
        PMS_MEDIUM_SPEED,
        PMS_SLEEP,
        PMS_SUBACTIVE,
        PMS_SUBSLEEP,
        PMS_WATCH,
        PMS_SW_STANDBY,
        PMS_HW_STANDBY
    } pms_mode_t;

    typedef struct packed {
        logic [PMS_NGROUP-1:0] clk_en;
        logic [PMS_NGROUP-1:0] reset;
    } pms_group_ctl_t;

    typedef struct packed {
        logic cpu_run;
        logic cpu_slow;
        logic main_osc_on;
        logic sub_osc_on;
        logic dtc_slow;
    } pms_core_ctl_t;

endpackage : pms_pkg

//--- bench/pms_power_ctrl_sva.sv
// Port checker for the power mode and module stop controller.
// Assumes a bind to pms_power_ctrl; everything on clk_sys.
`timescale 1ns/10ps
module pms_power_ctrl_sva
    import pms_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst, // Reset, active high
    input wire logic hw_standby_n, // Standby pin
    input wire logic reset_n_pin, // Reset pin
    input wire logic sleep_req, // Sleep pulse
    input wire logic int_accept, // Wake pulse
    input wire logic [3:0] reg_addr, // Address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [7:0] reg_rdata, // Read data
    input wire pms_mode_t mode, // Mode
    input wire pms_group_ctl_t group_ctl, // Group control
    input wire pms_core_ctl_t core_ctl // Core control
);
    // ----------------------------------------
    // Pin quiet counter
    // ----------------------------------------
    // Pins are synchronised, so mode rules hold only after 3 quiet edges
    logic [1:0] quiet;
    always_ff @(posedge clk_sys)
    begin
        if (rst || !hw_standby_n || !reset_n_pin)
            quiet <= 2'h0;
        else if (quiet != 2'h3)
            quiet <= quiet + 2'h1;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    property p_rd_unmapped;
        reg_rd && reg_addr > 4'h3 |=> reg_rdata == 8'h00;
    endproperty
    // One idle cycle between write and read, as the bench tasks leave
    property p_wr_rd;
        reg_wr && reg_addr < 4'h2 && quiet == 2'h3 && mode != PMS_RESET
        && mode != PMS_HW_STANDBY ##1 !reg_wr
        ##1 reg_rd && reg_addr == $past(reg_addr, 2)
        |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    property p_sleep_leaves;
        mode == PMS_HIGH_SPEED && sleep_req && quiet == 2'h3
        |=> mode != PMS_HIGH_SPEED;
    endproperty
    property p_run_holds;
        mode == PMS_HIGH_SPEED && !sleep_req && quiet == 2'h3
        |=> mode inside {PMS_HIGH_SPEED, PMS_MEDIUM_SPEED};
    endproperty
    property p_wake;
        mode == PMS_SLEEP && int_accept && quiet == 2'h3
        |=> mode inside {PMS_HIGH_SPEED, PMS_MEDIUM_SPEED};
    endproperty
    property p_halt_holds;
        mode == PMS_SLEEP && !int_accept && quiet == 2'h3
        |=> mode == PMS_SLEEP;
    endproperty
    property p_standby;
        !hw_standby_n [*4] |=> mode == PMS_HW_STANDBY;
    endproperty
    property p_reset_pin;
        (!reset_n_pin && hw_standby_n) [*5] |=> mode == PMS_RESET;
    endproperty
    property p_sw_gate;
        mode == PMS_SW_STANDBY && $past(mode) == PMS_SW_STANDBY
        |-> group_ctl.clk_en == '0 && !core_ctl.cpu_run
        && !core_ctl.main_osc_on;
    endproperty
    property p_hw_reset;
        mode == PMS_HW_STANDBY && $past(mode) == PMS_HW_STANDBY
        |-> &group_ctl.reset && group_ctl.clk_en == '0;
    endproperty

    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("bad unmapped");
    a_wr_rd: assert property (p_wr_rd) else $error("readback mismatch");
    a_sleep_leaves: assert property (p_sleep_leaves) else $error("no halt");
    a_run_holds: assert property (p_run_holds) else $error("left run");
    a_wake: assert property (p_wake) else $error("no wake");
    a_halt_holds: assert property (p_halt_holds) else $error("left sleep");
    a_standby: assert property (p_standby) else $error("no standby");
    a_reset_pin: assert property (p_reset_pin) else $error("no reset");
    a_sw_gate: assert property (p_sw_gate) else $error("clocks run");
    a_hw_reset: assert property (p_hw_reset) else $error("groups live");

    c_sleep: cover property (mode == PMS_SLEEP && int_accept);
    c_sw: cover property (mode == PMS_SW_STANDBY);
    c_hw: cover property (mode == PMS_HW_STANDBY);
    c_medium: cover property (mode == PMS_MEDIUM_SPEED);
endmodule : pms_power_ctrl_sva

//--- bench/pms_cpu_model.sv
// CPU core stand-in: turns bench commands into sleep and wake pulses.
// Assumes commands are one-cycle levels on clk_sys.
`timescale 1ns/10ps
module pms_cpu_model
(
    input wire logic clk_sys, // System clock
    input wire logic rst, // Reset, active high
    input wire logic cmd_sleep, // Execute the sleep instruction
    input wire logic cmd_irq, // Raise an interrupt
    input wire logic [3:0] irq_lag, // Cycles until it is accepted
    output logic sleep_req, // Sleep pulse
    output logic int_accept // Wake pulse
);
    logic sreq = 1'b0;
    logic iacc = 1'b0;
    logic pend = 1'b0;
    logic [3:0] lag = 4'h0;
    assign sleep_req = sreq;
    assign int_accept = iacc;
    always @(posedge clk_sys)
        sreq <= !rst && cmd_sleep;
    always @(posedge clk_sys)
    begin
        iacc <= 1'b0;
        if (rst)
            pend <= 1'b0;
        else if (cmd_irq)
        begin
            pend <= 1'b1;
            lag <= irq_lag;
        end
        else if (pend && lag == 4'h0)
        begin
            pend <= 1'b0;
            iacc <= 1'b1;
        end
        else if (pend)
            lag <= lag - 4'h1;
    end
endmodule : pms_cpu_model

//--- bench/pms_power_ctrl_tb.sv
// Self-checking bench for the power mode and module stop controller.
// Assumes pms_pkg, the design, the checker and the CPU model compiled.
`timescale 1ns/10ps
module pms_power_ctrl_tb
    import pms_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hw_standby_n = 1'b1;
    logic reset_n_pin = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic cmd_sleep = 1'b0;
    logic cmd_irq = 1'b0;
    logic [3:0] irq_lag = 4'h0;
    logic sleep_req;
    logic int_accept;
    logic [7:0] reg_rdata;
    pms_mode_t mode;
    pms_group_ctl_t group_ctl;
    pms_core_ctl_t core_ctl;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int seed;
    logic [7:0] m_hi;
    logic [7:0] m_lo;
    logic [7:0] d;
    logic [7:0] wq[$];

    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    pms_power_ctrl uut (.clk_sys(clk_sys), .rst(rst),
        .hw_standby_n(hw_standby_n), .reset_n_pin(reset_n_pin),
        .sleep_req(sleep_req), .int_accept(int_accept),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode(mode),
        .group_ctl(group_ctl), .core_ctl(core_ctl));
    pms_cpu_model u_cpu (.clk_sys(clk_sys), .rst(rst),
        .cmd_sleep(cmd_sleep), .cmd_irq(cmd_irq), .irq_lag(irq_lag),
        .sleep_req(sleep_req), .int_accept(int_accept));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        if (a == 4'h0)
            m_hi = v;
        if (a == 4'h1)
            m_lo = v;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk({8'h0, reg_rdata}, {8'h0, exp});
    endtask : rd

    task automatic cpu(input logic slp, input logic [3:0] lag);
        @(posedge clk_sys);
        cmd_sleep <= slp;
        cmd_irq <= !slp;
        irq_lag <= lag;
        @(posedge clk_sys);
        cmd_sleep <= 1'b0;
        cmd_irq <= 1'b0;
    endtask : cpu

    // Waits out sync and model lag, then lets group_ctl follow mode
    task automatic wait_mode(input pms_mode_t m);
        int n;
        n = 0;
        while (mode !== m && n < 24)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk({12'h0, mode}, {12'h0, m});
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : wait_mode

    function automatic logic [13:0] run_en(input logic [7:0] hi,
        input logic [7:0] lo);
        logic [13:0] s;
        for (int i = 0; i < 7; i++)
            s[i] = hi[6-i];
        for (int i = 0; i < 6; i++)
            s[7+i] = lo[7-i];
        s[13] = lo[0];
        return ~s;
    endfunction : run_en

    task automatic chk_regs;
        rd(4'h0, m_hi);
        rd(4'h1, m_lo);
        chk({2'h0, group_ctl.clk_en}, {2'h0, run_en(m_hi, m_lo)});
    endtask : chk_regs

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            $display("[ERR] %0t run too long", $time);
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        seed = 87777;
        m_hi = 8'h3f;
        m_lo = 8'hff;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        wait_mode(PMS_HIGH_SPEED);
        chk_regs();
        $display("test reset_values done");
        repeat (12)
        begin
            // software keeps the reserved bit clear
            wq.push_back(8'($random(seed)) & PMS_HIGH_WRITE_MASK);
            wq.push_back(8'($random(seed)));
            wr(4'h0, wq.pop_front());
            wr(4'h1, wq.pop_front());
            rd(4'h1, m_lo);
            wr(4'h9, 8'($random(seed)));
            rd(4'h9, 8'h00);
            rd(4'h2, {4'h0, PMS_HIGH_SPEED});
            chk_regs();
            chk(group_ctl.reset[PMS_G_SERIAL0], m_lo[7]);
            chk(group_ctl.reset[PMS_G_FREERUN], 1'b0);
        end
        $display("test stop_bits done");
        wr(4'h3, 8'h00);
        cpu(1'b0, 4'h0);
        repeat (4) @(posedge clk_sys);
        wait_mode(PMS_HIGH_SPEED);
        cpu(1'b1, 4'h0);
        wait_mode(PMS_SLEEP);
        chk_regs();
        cpu(1'b1, 4'h0);
        repeat (4) @(posedge clk_sys);
        wait_mode(PMS_SLEEP);
        cpu(1'b0, 4'h9);
        wait_mode(PMS_HIGH_SPEED);
        wr(4'h3, 8'h04);
        cpu(1'b1, 4'h0);
        wait_mode(PMS_SLEEP);
        cpu(1'b0, 4'h2);
        wait_mode(PMS_MEDIUM_SPEED);
        chk(core_ctl.dtc_slow, 1'b1);
        chk({core_ctl.cpu_slow, core_ctl.sub_osc_on}, 16'h3);
        chk_regs();
        $display("test sleep_medium done");
        wr(4'h3, 8'h01);
        cpu(1'b1, 4'h0);
        wait_mode(PMS_SW_STANDBY);
        chk({2'h0, group_ctl.clk_en}, 16'h0);
        chk(group_ctl.reset[PMS_G_PULSE], 1'b1);
        chk(group_ctl.reset[PMS_G_SERIAL2], 1'b1);
        chk(group_ctl.reset[PMS_G_TRANSFER], 1'b0);
        chk({core_ctl.cpu_run, core_ctl.main_osc_on, core_ctl.sub_osc_on},
            16'h0);
        wr(4'h3, 8'h00);
        cpu(1'b0, 4'h0);
        wait_mode(PMS_HIGH_SPEED);
        chk_regs();
        $display("test sw_standby done");
        wr(4'h3, 8'h02);
        cpu(1'b1, 4'h0);
        wait_mode(PMS_WATCH);
        chk({2'h0, group_ctl.clk_en}, 16'h0);
        chk(group_ctl.reset[PMS_G_TRANSFER], 1'b0);
        chk(group_ctl.reset[PMS_G_SERIAL0], 1'b1);
        cpu(1'b0, 4'h1);
        wait_mode(PMS_SUBACTIVE);
        chk({core_ctl.cpu_run, core_ctl.cpu_slow}, 16'h3);
        cpu(1'b1, 4'h0);
        wait_mode(PMS_SUBSLEEP);
        cpu(1'b0, 4'h0);
        wait_mode(PMS_SUBACTIVE);
        wr(4'h3, 8'h00);
        cpu(1'b1, 4'h0);
        wait_mode(PMS_WATCH);
        cpu(1'b0, 4'h0);
        wait_mode(PMS_HIGH_SPEED);
        $display("test low_speed done");
        hw_standby_n <= 1'b0;
        reset_n_pin <= 1'b0;
        wait_mode(PMS_HW_STANDBY);
        repeat (6) @(posedge clk_sys);
        wait_mode(PMS_HW_STANDBY);
        chk(&group_ctl.reset, 1'b1);
        hw_standby_n <= 1'b1;
        wait_mode(PMS_RESET);
        reset_n_pin <= 1'b1;
        wait_mode(PMS_HIGH_SPEED);
        m_hi = 8'h3f;
        m_lo = 8'hff;
        chk_regs();
        cpu(1'b1, 4'h0);
        wait_mode(PMS_SLEEP);
        reset_n_pin <= 1'b0;
        wait_mode(PMS_RESET);
        reset_n_pin <= 1'b1;
        wait_mode(PMS_HIGH_SPEED);
        $display("test pins done");
        tally_and_finish();
    end
endmodule : pms_power_ctrl_tb

bind pms_power_ctrl pms_power_ctrl_sva u_sva (.clk_sys(clk_sys),
    .rst(rst), .hw_standby_n(hw_standby_n), .reset_n_pin(reset_n_pin),
    .sleep_req(sleep_req), .int_accept(int_accept), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mode(mode), .group_ctl(group_ctl),
    .core_ctl(core_ctl));
